/* File: common/dbmhp_defines.vh */
// Purpose: constants for the disk buffer manager host port
// Assumes: included by hw/dbmhp_top.v
// Notes: offsets are internal or host register indices
`ifndef DBMHP_DEFINES_VH
`define DBMHP_DEFINES_VH
// control processor support command addresses (low six bits)
`define DBMHP_CMD_HBLK 6'h20
`define DBMHP_CMD_FBLK 6'h21
`define DBMHP_CMD_HCLR 6'h22
`define DBMHP_CMD_FCLR 6'h23
`define DBMHP_CMD_DRQ 6'h24
`define DBMHP_CMD_RDM 6'h25
`define DBMHP_CMD_MULT 6'h26
`define DBMHP_CMD_SBLK 6'h27
// internal address ranges (top two of low six bits)
`define DBMHP_RNG_OWN 2'h0
`define DBMHP_RNG_TF 2'h1
`define DBMHP_RNG_CMD 2'h2
`define DBMHP_RNG_SPC 2'h3
// own register indices in range 00-07
`define DBMHP_OWN_STAT 3'h0
`define DBMHP_OWN_HADR_LO 3'h1
`define DBMHP_OWN_HADR_HI 3'h2
`define DBMHP_OWN_FADR_LO 3'h3
`define DBMHP_OWN_FADR_HI 3'h4
`define DBMHP_OWN_SBLK 3'h5
`define DBMHP_OWN_AUX 3'h6
// host register selects: {a9, a2..a0}
`define DBMHP_HOST_DATA 4'h0
`define DBMHP_HOST_CMD 4'h7
`define DBMHP_HOST_ASTAT 4'he
// aux control register fields
`define DBMHP_AUX_IDS 1
`define DBMHP_AUX_RST 2
// status image field positions
`define DBMHP_ST_BZY 7
`define DBMHP_ST_DRQ 3
// reset values
`define DBMHP_AUX_RESET 8'h02
`define DBMHP_ST_RESET 8'h00
// sequencer states
`define DBMHP_SQ_IDLE 2'h0
`define DBMHP_SQ_HOST 2'h1
`define DBMHP_SQ_FMT 2'h2
`define DBMHP_SQ_DONE 2'h3
`endif

/* File: hw/dbmhp_top.v */
// Purpose: buffer manager: host decode, task file images, data pipeline,
//   sector ram address counters, arbitration and support commands
// Assumes: host strobes and formatter request arrive asynchronously and
//   are synchronised; control processor is on classic wishbone, mclk
// Notes: internal address = wb_adr_i[7:0], one aligned word each
// Functional notes
// - host interrupt out only when disable bit clear and not busy
// - any host command, programmed reset or master reset clears interrupt
// - processor reads and writes host and formatter block counters 20, 21
// - write 22 clears host address counter, write 23 formatter counter
// - read 22 enters sleep mode and clears busy
// - read 23 selects 7-byte ecc; write 24 sets drq; read 24 interrupt
// - write 25 read mode; read 25 prefetch; write/read 26 multi set/clear
// - write 27 loads sector block counter; read 27 enters idle mode
// - ranges: 00-07 own, 10-17 task file, 30-3f special
// - top two internal address bits ignored in command decode
// - support commands only from processor bus, not host
// - host sees task file images only; processor sees both
// - arbitrate host/formatter, drive winner counter onto ram address
// - clocked sequencer favours host, makes ram strobes and byte gate
// - 14-bit incrementing counters, upper 13 bits address, lsb byte lane
// - respond to primary or alternate host range, selected externally
// - host a9 and a2..a0 select the register
// - wakeup driven to processor input beside formatter signals
// - disable bit masks output but keeps pending level
// - interrupt disabled after master reset
// - host write word held in pipeline, written to ram between cycles
// - host read returns prefetched word and prefetches the next
`include "dbmhp_defines.vh"
module dbmhp_top (
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // control processor wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // host bus
  input wire host_sel_n,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire host_a9,
  input wire [2:0] host_a,
  input wire [15:0] host_d_i,
  output reg [15:0] host_d_o,
  output reg host_d_oe,
  output reg host_irq,
  // formatter side
  input wire formatter_buffer_request,
  input wire formatter_done_signal,
  input wire [7:0] fmt_d_i,
  output reg [7:0] fmt_d_o,
  output reg fmt_ack,
  // sector ram
  output reg [12:0] ram_addr,
  output reg ram_oe_n,
  output reg ram_we_n,
  output reg [15:0] ram_d_o,
  input wire [15:0] ram_d_i,
  output reg byte_gate,
  // processor input port
  output reg wakeup_signal,
  output reg fmt_done_out,
  output reg fmt_breq_out
);

// ---------------------------------------------------------------
// input synchronisers
// ---------------------------------------------------------------
reg [2:0] hs_s1_q, hs_s2_q;
reg [1:0] fs_s1_q, fs_s2_q;
reg hwr_prev_q, hrd_prev_q;
reg [3:0] hadr_q;
reg [15:0] hdat_q;
reg [27:0] pin_s1_q, pin_s2_q; // {fmt_d_i, host_a9, host_a, host_d_i}
// strobe decode reads only the second flop
wire host_wr = ~hs_s2_q[2] & ~hs_s2_q[0];
wire host_rd = ~hs_s2_q[2] & ~hs_s2_q[1];
wire hwr_end = hwr_prev_q & ~host_wr;
wire hrd_end = hrd_prev_q & ~host_rd;
wire hrd_go = host_rd & ~hrd_prev_q;
wire [7:0] fmt_byte = pin_s2_q[27:20];
// two flops for strobes, formatter signals and pin buses, kept in step
always @(posedge mclk) begin
  if (sys_rst) begin
    hs_s1_q <= 3'h7;
    hs_s2_q <= 3'h7;
    fs_s1_q <= 2'h0;
    fs_s2_q <= 2'h0;
    pin_s1_q <= 28'h0000000;
    pin_s2_q <= 28'h0000000;
    hwr_prev_q <= 1'b0;
    hrd_prev_q <= 1'b0;
  end else if (clk_en) begin
    hs_s1_q <= {host_sel_n, host_rd_n, host_wr_n};
    hs_s2_q <= hs_s1_q;
    fs_s1_q <= {formatter_buffer_request, formatter_done_signal};
    fs_s2_q <= fs_s1_q;
    pin_s1_q <= {fmt_d_i, host_a9, host_a, host_d_i};
    pin_s2_q <= pin_s1_q;
    hwr_prev_q <= host_wr;
    hrd_prev_q <= host_rd;
  end
end

// address and data stable while strobe held; captured on strobe
always @(posedge mclk) begin
  if (sys_rst) begin
    hadr_q <= 4'h0;
    hdat_q <= 16'h0000;
  end else if (clk_en && (host_wr | host_rd)) begin
    hadr_q <= pin_s2_q[19:16];
    hdat_q <= pin_s2_q[15:0];
  end
end

// ---------------------------------------------------------------
// processor bus decode
// ---------------------------------------------------------------
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire [1:0] rng = wb_adr_i[5:4];
wire [5:0] cadr = wb_adr_i[5:0];
wire cmd_wr = wb_req & wb_we_i & wb_sel_i[0] & (rng == `DBMHP_RNG_CMD);
wire cmd_rd = wb_req & ~wb_we_i & (rng == `DBMHP_RNG_CMD);

function hit;
  input strobe;
  input [5:0] a;
  input [5:0] want;
  begin
    hit = strobe & (a == want);
  end
endfunction

// ---------------------------------------------------------------
// control state
// ---------------------------------------------------------------
reg [7:0] aux_control_reg_q;
reg [7:0] img_q [0:7];
reg [7:0] tf_q [0:7];
reg irq_lvl_q, busy_q, sleep_q, ecc7_q, drq_q, rdmode_q, multi_q, idle_q;
reg [7:0] hblk_q, fblk_q, sblk_q;
reg [13:0] hcnt_q, fcnt_q;
reg pf_req_q, pf_valid_q, wp_req_q, fmt_pend_q, fmt_prev_q;
reg [15:0] pipe_q;
reg [1:0] sq_q;
integer i;

wire host_cmd = hwr_end & (hadr_q == `DBMHP_HOST_CMD);
wire host_data_wr = hwr_end & (hadr_q == `DBMHP_HOST_DATA);
wire host_data_rd = hrd_end & (hadr_q == `DBMHP_HOST_DATA);
wire prst = aux_control_reg_q[`DBMHP_AUX_RST];
wire fmt_rise = fs_s2_q[1] & ~fmt_prev_q;

// aux register, images, task file, mode latches, interrupt level
always @(posedge mclk) begin
  if (sys_rst) begin
    aux_control_reg_q <= `DBMHP_AUX_RESET;
    for (i = 0; i < 8; i = i + 1) begin
      img_q[i] <= `DBMHP_ST_RESET;
      tf_q[i] <= 8'h00;
    end
    irq_lvl_q <= 1'b0;
    busy_q <= 1'b0;
    sleep_q <= 1'b0;
    ecc7_q <= 1'b0;
    drq_q <= 1'b0;
    rdmode_q <= 1'b0;
    multi_q <= 1'b0;
    idle_q <= 1'b1;
    hblk_q <= 8'h00;
    fblk_q <= 8'h00;
    sblk_q <= 8'h00;
  end else if (clk_en) begin
    // host writes reach images only, plus the aux register at select e
    if (hwr_end && !hadr_q[3] && hadr_q != `DBMHP_HOST_DATA)
      img_q[hadr_q[2:0]] <= hdat_q[7:0];
    if (hwr_end && hadr_q == `DBMHP_HOST_ASTAT)
      aux_control_reg_q <= hdat_q[7:0];
    // processor writes to own and task file ranges
    if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (rng == `DBMHP_RNG_OWN && cadr[3] == 1'b0) begin
        if (cadr[2:0] == `DBMHP_OWN_AUX)
          aux_control_reg_q <= wb_dat_i[7:0];
        else
          img_q[cadr[2:0]] <= wb_dat_i[7:0];
      end
      if (rng == `DBMHP_RNG_TF && cadr[3] == 1'b0)
        tf_q[cadr[2:0]] <= wb_dat_i[7:0];
    end
    if (hit(cmd_wr, cadr, `DBMHP_CMD_HBLK)) hblk_q <= wb_dat_i[7:0];
    if (hit(cmd_wr, cadr, `DBMHP_CMD_FBLK)) fblk_q <= wb_dat_i[7:0];
    if (hit(cmd_rd, cadr, `DBMHP_CMD_HCLR)) begin
      sleep_q <= 1'b1;
      busy_q <= 1'b0;
    end
    // host command sets busy; wins over a same-cycle processor clear
    if (host_cmd) begin
      busy_q <= 1'b1;
      sleep_q <= 1'b0;
      idle_q <= 1'b0;
    end
    if (hit(cmd_rd, cadr, `DBMHP_CMD_FCLR)) ecc7_q <= 1'b1;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_DRQ)) drq_q <= 1'b1;
    if (host_data_wr | host_data_rd) drq_q <= 1'b0;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_RDM)) rdmode_q <= 1'b1;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_MULT)) multi_q <= 1'b1;
    if (hit(cmd_rd, cadr, `DBMHP_CMD_MULT)) multi_q <= 1'b0;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_SBLK)) sblk_q <= wb_dat_i[7:0];
    if (hit(cmd_rd, cadr, `DBMHP_CMD_SBLK)) idle_q <= 1'b1;
    // interrupt level: host command or programmed reset clear it
    if (host_cmd | prst)
      irq_lvl_q <= 1'b0;
    else if (hit(cmd_rd, cadr, `DBMHP_CMD_DRQ))
      irq_lvl_q <= 1'b1;
    if (prst) begin
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      multi_q <= 1'b0;
    end
  end
end

// ---------------------------------------------------------------
// address counters, pipeline and sequencer
// ---------------------------------------------------------------
wire host_wins = pf_req_q | wp_req_q;
wire fmt_want = fmt_pend_q | fmt_rise;
always @(posedge mclk) begin
  if (sys_rst) begin
    hcnt_q <= 14'h0000;
    fcnt_q <= 14'h0000;
    pf_req_q <= 1'b0;
    pf_valid_q <= 1'b0;
    wp_req_q <= 1'b0;
    fmt_pend_q <= 1'b0;
    fmt_prev_q <= 1'b0;
    pipe_q <= 16'h0000;
    sq_q <= `DBMHP_SQ_IDLE;
    ram_addr <= 13'h0000;
    ram_oe_n <= 1'b1;
    ram_we_n <= 1'b1;
    ram_d_o <= 16'h0000;
    byte_gate <= 1'b0;
    fmt_ack <= 1'b0;
    fmt_d_o <= 8'h00;
  end else if (clk_en) begin
    fmt_prev_q <= fs_s2_q[1];
    fmt_ack <= 1'b0;
    if (fmt_rise) fmt_pend_q <= 1'b1;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_HCLR)) hcnt_q <= 14'h0000;
    if (hit(cmd_wr, cadr, `DBMHP_CMD_FCLR)) fcnt_q <= 14'h0000;
    case (sq_q)
      `DBMHP_SQ_IDLE: begin
        if (host_wins) begin
          sq_q <= `DBMHP_SQ_HOST;
          ram_addr <= hcnt_q[13:1];
          ram_oe_n <= ~pf_req_q;
          ram_we_n <= pf_req_q;
          ram_d_o <= pipe_q;
          byte_gate <= 1'b1;
        end else if (fmt_want) begin
          sq_q <= `DBMHP_SQ_FMT;
          ram_addr <= fcnt_q[13:1];
          ram_oe_n <= rdmode_q;
          ram_we_n <= ~rdmode_q;
          ram_d_o <= {fmt_byte, fmt_byte};
        end
      end
      `DBMHP_SQ_HOST: begin
        if (!ram_oe_n) begin
          pipe_q <= ram_d_i;
          pf_valid_q <= 1'b1;
          pf_req_q <= 1'b0;
        end else begin
          wp_req_q <= 1'b0;
        end
        hcnt_q <= hcnt_q + 14'h0002;
        sq_q <= `DBMHP_SQ_DONE;
      end
      `DBMHP_SQ_FMT: begin
        fmt_d_o <= fcnt_q[0] ? ram_d_i[15:8] : ram_d_i[7:0];
        fcnt_q <= fcnt_q + 14'h0001;
        fmt_pend_q <= fmt_rise;
        fmt_ack <= 1'b1;
        sq_q <= `DBMHP_SQ_DONE;
      end
      `DBMHP_SQ_DONE: begin
        ram_oe_n <= 1'b1;
        ram_we_n <= 1'b1;
        byte_gate <= 1'b0;
        sq_q <= `DBMHP_SQ_IDLE;
      end
      default: sq_q <= `DBMHP_SQ_IDLE;
    endcase
    // new host requests after the sequencer so a same-cycle clear never drops them
    if (hit(cmd_rd, cadr, `DBMHP_CMD_RDM)) begin
      pf_req_q <= 1'b1;
      pf_valid_q <= 1'b0;
    end
    if (host_data_rd) begin
      pf_req_q <= 1'b1;
      pf_valid_q <= 1'b0;
    end
    if (host_data_wr) begin
      pipe_q <= hdat_q;
      wp_req_q <= 1'b1;
    end
  end
end

// ---------------------------------------------------------------
// host read data, interrupt and processor port
// ---------------------------------------------------------------
wire [7:0] astat = {busy_q, img_q[0][6:4], drq_q, img_q[0][2:0]};
always @(posedge mclk) begin
  if (sys_rst) begin
    host_d_o <= 16'h0000;
    host_d_oe <= 1'b0;
    host_irq <= 1'b0;
    wakeup_signal <= 1'b0;
    fmt_done_out <= 1'b0;
    fmt_breq_out <= 1'b0;
  end else if (clk_en) begin
    host_d_oe <= host_rd;
    if (hrd_go) begin
      if (hadr_q == `DBMHP_HOST_DATA)
        host_d_o <= pipe_q;
      else if (hadr_q == `DBMHP_HOST_ASTAT || hadr_q == `DBMHP_HOST_CMD)
        host_d_o <= {8'h00, astat};
      else
        host_d_o <= {8'h00, img_q[hadr_q[2:0]]};
    end
    host_irq <= irq_lvl_q & ~busy_q & ~aux_control_reg_q[`DBMHP_AUX_IDS];
    wakeup_signal <= host_cmd | (wakeup_signal & sleep_q);
    fmt_done_out <= fs_s2_q[0];
    fmt_breq_out <= fs_s2_q[1];
  end
end

// processor read mux and ack, one wait cycle
always @(posedge mclk) begin
  if (sys_rst) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else if (clk_en) begin
    wb_ack_o <= wb_req;
    if (wb_req && !wb_we_i) begin
      wb_dat_o <= 32'h00000000;
      case (rng)
        `DBMHP_RNG_OWN:
          case (cadr[2:0])
            `DBMHP_OWN_STAT: wb_dat_o[7:0] <= {irq_lvl_q, busy_q, sleep_q, ecc7_q,
                                                drq_q, rdmode_q, multi_q, idle_q};
            `DBMHP_OWN_HADR_LO: wb_dat_o[7:0] <= hcnt_q[7:0];
            `DBMHP_OWN_HADR_HI: wb_dat_o[5:0] <= hcnt_q[13:8];
            `DBMHP_OWN_FADR_LO: wb_dat_o[7:0] <= fcnt_q[7:0];
            `DBMHP_OWN_FADR_HI: wb_dat_o[5:0] <= fcnt_q[13:8];
            `DBMHP_OWN_SBLK: wb_dat_o[7:0] <= sblk_q;
            `DBMHP_OWN_AUX: wb_dat_o[7:0] <= aux_control_reg_q;
            default: wb_dat_o[7:0] <= img_q[7];
          endcase
        `DBMHP_RNG_TF: wb_dat_o[7:0] <= tf_q[cadr[2:0]];
        `DBMHP_RNG_CMD:
          if (cadr == `DBMHP_CMD_HBLK) wb_dat_o[7:0] <= hblk_q;
          else if (cadr == `DBMHP_CMD_FBLK) wb_dat_o[7:0] <= fblk_q;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
end

endmodule // dbmhp_top

/* File: test/dbmhp_top_asserts.sv */
// Purpose: port checker for the buffer manager host port
// Assumes: bound to dbmhp_top, one clock mclk
// Notes: sees the top module's ports only
module dbmhp_asserts (
  input wire mclk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire host_sel_n,
  input wire host_rd_n,
  input wire host_wr_n,
  input wire host_a9,
  input wire [2:0] host_a,
  input wire host_d_oe,
  input wire host_irq,
  input wire formatter_buffer_request,
  input wire formatter_done_signal,
  input wire fmt_ack,
  input wire ram_oe_n,
  input wire ram_we_n,
  input wire wakeup_signal,
  input wire fmt_done_out,
  input wire byte_gate,
  input wire fmt_breq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // host strobe events
  // ----------------------------------------
  sequence s_cmd_end;
    $rose(host_wr_n) && !host_sel_n && !host_a9 && host_a == 3'h7;
  endsequence
  sequence s_rd_start;
    $fell(host_rd_n) && !host_sel_n;
  endsequence
  // bus answer, interrupt and sequencer checks
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_irq_after_reset: assert property ($past(sys_rst) |-> !host_irq)
    else $error("irq after reset");
  a_cmd_clears_irq: assert property (s_cmd_end |-> ##[1:6] !host_irq)
    else $error("irq kept after command");
  a_cmd_wakes: assert property (s_cmd_end |-> ##[1:6] wakeup_signal)
    else $error("no wakeup after command");
  a_read_drives: assert property (s_rd_start |-> ##[1:5] host_d_oe)
    else $error("host data not driven");
  a_fmt_served: assert property ($rose(formatter_buffer_request) |-> ##[1:16] fmt_ack)
    else $error("formatter request lost");
  a_strobe_excl: assert property (!(!ram_oe_n && !ram_we_n))
    else $error("ram read and write together");
  a_done_fwd: assert property ($rose(formatter_done_signal) |-> ##[1:4] fmt_done_out)
    else $error("done not forwarded");
  a_gate_strobe: assert property (byte_gate |-> (!ram_oe_n || !ram_we_n))
    else $error("byte gate without ram strobe");
  a_breq_fwd: assert property ($rose(formatter_buffer_request) |-> ##[1:4] fmt_breq_out)
    else $error("buffer request not forwarded");
endmodule // dbmhp_asserts

bind dbmhp_top dbmhp_asserts i_chk (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .host_sel_n(host_sel_n), .host_rd_n(host_rd_n),
  .host_wr_n(host_wr_n), .host_a9(host_a9), .host_a(host_a), .host_d_oe(host_d_oe),
  .host_irq(host_irq), .formatter_buffer_request(formatter_buffer_request),
  .formatter_done_signal(formatter_done_signal), .fmt_ack(fmt_ack), .ram_oe_n(ram_oe_n),
  .ram_we_n(ram_we_n), .wakeup_signal(wakeup_signal), .fmt_done_out(fmt_done_out),
  .byte_gate(byte_gate), .fmt_breq_out(fmt_breq_out));

/* File: test/dbmhp_far_model.sv */
// Purpose: sector ram and formatter request model
// Assumes: go is a one-cycle pulse from the bench
// Notes: released ram bus shows the inverse of the last word
module dbmhp_far_model (
  input wire mclk,
  input wire go,
  input wire [12:0] ram_addr,
  input wire ram_oe_n,
  input wire ram_we_n,
  input wire [15:0] ram_d_o,
  input wire fmt_ack,
  output logic [15:0] ram_d_i,
  output logic breq,
  output int served
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:8191];
  logic [15:0] last = 16'h0000;
  initial begin
    breq = 1'b0;
    served = 0;
  end
  // ram word store, written on the write strobe
  always @(posedge mclk) begin
    if (!ram_we_n)
      mem[ram_addr] <= ram_d_o;
    if (!ram_oe_n)
      last <= mem[ram_addr];
  end
  assign ram_d_i = ram_oe_n ? ~last : mem[ram_addr];
  // request held until acknowledged
  always @(posedge mclk) begin
    if (go && !breq)
      breq <= 1'b1;
    else if (breq && fmt_ack) begin
      breq <= 1'b0;
      served <= served + 1;
    end
  end
endmodule // dbmhp_far_model

/* File: test/test_disk_buffer_manager_host_port.sv */
// Purpose: self-checking bench for dbmhp_top
// Assumes: wishbone ack one cycle after request, host strobes >= 6 apart
// Notes: table rows cover support commands, hand tests the rest
module test_disk_buffer_manager_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, done_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, a9 = 1'b0;
  logic [2:0] ha = 3'h0;
  logic [15:0] hd = 16'h0, hrd, ram_d_i, ram_d_o, host_d_o;
  wire [31:0] wb_dat_o;
  wire [12:0] ram_addr;
  wire [7:0] fmt_d_o;
  wire wb_ack_o, host_d_oe, host_irq, fmt_ack, ram_oe_n, ram_we_n, breq, fmt_done_out;
  int served, fail_count = 0, checks = 0;
  // {write, first addr, data, read addr, mask, expected}
  logic [40:0] rows [13] = '{{1'h1, 8'h20, 8'h5a, 8'h20, 8'hff, 8'h5a},
    {1'h1, 8'h21, 8'ha5, 8'h21, 8'hff, 8'ha5}, {1'h1, 8'he0, 8'h3c, 8'h20, 8'hff, 8'h3c},
    {1'h1, 8'h26, 8'h00, 8'h00, 8'h02, 8'h02}, {1'h0, 8'h26, 8'h00, 8'h00, 8'h02, 8'h00},
    {1'h1, 8'h25, 8'h00, 8'h00, 8'h04, 8'h04}, {1'h1, 8'h24, 8'h00, 8'h00, 8'h08, 8'h08},
    {1'h0, 8'h23, 8'h00, 8'h00, 8'h10, 8'h10}, {1'h0, 8'h22, 8'h00, 8'h00, 8'h60, 8'h20},
    {1'h0, 8'h27, 8'h00, 8'h00, 8'h01, 8'h01}, {1'h1, 8'h27, 8'h11, 8'h05, 8'hff, 8'h11},
    {1'h1, 8'h1c, 8'h77, 8'h1c, 8'hff, 8'h00}, {1'h1, 8'h23, 8'h00, 8'h03, 8'hff, 8'h00}};
  always #2.5 mclk = ~mclk;
  dbmhp_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_sel_n(sel_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .host_a9(a9), .host_a(ha), .host_d_i(hd), .host_d_o(host_d_o),
    .host_d_oe(host_d_oe), .host_irq(host_irq), .formatter_buffer_request(breq),
    .formatter_done_signal(done_in), .fmt_d_i(8'h5c), .fmt_d_o(fmt_d_o), .fmt_ack(fmt_ack),
    .ram_addr(ram_addr), .ram_oe_n(ram_oe_n), .ram_we_n(ram_we_n), .ram_d_o(ram_d_o),
    .ram_d_i(ram_d_i), .byte_gate(), .wakeup_signal(), .fmt_done_out(fmt_done_out),
    .fmt_breq_out());
  dbmhp_far_model far (.mclk(mclk), .go(go), .ram_addr(ram_addr), .ram_oe_n(ram_oe_n),
    .ram_we_n(ram_we_n), .ram_d_o(ram_d_o), .fmt_ack(fmt_ack), .ram_d_i(ram_d_i),
    .breq(breq), .served(served));
  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      results;
    end else begin
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task automatic host(input logic w, input logic [3:0] s, input logic [15:0] d);
    sel_n <= 1'b0;
    {a9, ha} <= s;
    hd <= d;
    @(posedge mclk);
    if (w) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    hrd = host_d_o;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge mclk);
    sel_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("irq", host_irq, 32'h0);
    wb(1'b0, 8'h06, 32'h0);
    chk("aux", rdat, 32'h02);
    $display("reset test done");
    for (int i = 0; i < 13; i++) begin
      wb(rows[i][40], rows[i][39:32], {24'h0, rows[i][31:24]});
      wb(1'b0, rows[i][23:16], 32'h0);
      chk("row", rdat & {24'h0, rows[i][15:8]}, {24'h0, rows[i][7:0]});
    end
    $display("command table test done");
    wb(1'b0, 8'h24, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq masked", host_irq, 32'h0);
    host(1'b1, 4'he, 16'h0000);
    repeat (4) @(posedge mclk);
    chk("irq shown", host_irq, 32'h1);
    host(1'b1, 4'h7, 16'h0020);
    chk("irq cleared", host_irq, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk("busy level", rdat & 32'hc0, 32'h40);
    chk("idle cleared", rdat & 32'h01, 32'h0);
    wb(1'b0, 8'h27, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk("idle set", rdat & 32'h01, 32'h1);
    wb(1'b0, 8'h24, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq busy", host_irq, 32'h0);
    wb(1'b0, 8'h22, 32'h0);
    repeat (2) @(posedge mclk);
    chk("irq not busy", host_irq, 32'h1);
    $display("interrupt test done");
    wb(1'b1, 8'h22, 32'h0);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    host(1'b1, 4'h0, 16'hbeef);
    repeat (8) @(posedge mclk);
    chk("ram word", far.mem[0], 32'hbeef);
    chk("served", served, 32'h1);
    wb(1'b1, 8'h22, 32'h0);
    wb(1'b0, 8'h25, 32'h0);
    repeat (8) @(posedge mclk);
    host(1'b0, 4'h0, 16'h0000);
    chk("host read", hrd, 32'hbeef);
    done_in <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("done out", fmt_done_out, 32'h1);
    done_in <= 1'b0;
    wb(1'b0, 8'h01, 32'h0);
    chk("host count", rdat, 32'h04);
    $display("data path test done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    wb(1'b0, 8'h06, 32'h0);
    chk("aux again", rdat, 32'h02);
    $display("second reset test done");
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("fmt low byte", fmt_d_o, 32'hef);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("fmt high byte", fmt_d_o, 32'hbe);
    chk("served again", served, 32'h3);
    wb(1'b0, 8'h03, 32'h0);
    chk("fmt count", rdat, 32'h02);
    wb(1'b1, 8'h23, 32'h0);
    wb(1'b0, 8'h03, 32'h0);
    chk("fmt count clear", rdat, 32'h0);
    $display("formatter read test done");
    results;
  end
endmodule // test_disk_buffer_manager_host_port
